// ---- rtl/gpo_pkg.sv ----
/*
 Package for the general purpose I/O ports with peripheral override.
 Assumes a classic Wishbone slave with 32-bit data, one register per word.
*/
package gpo_pkg;
	// ============================================================
	// Widths
	localparam int unsigned GPO_ADDR_W = 8;
	localparam int unsigned GPO_DATA_W = 32;
	localparam int unsigned GPO_PORT_W = 8;

	// ============================================================
	// Register indices (byte address is four times the index)
	localparam logic [7:0] GPO_IDX_B_IN   = 8'h03;
	localparam logic [7:0] GPO_IDX_B_DIR  = 8'h04;
	localparam logic [7:0] GPO_IDX_B_OUT  = 8'h05;
	localparam logic [7:0] GPO_IDX_C_IN   = 8'h06;
	localparam logic [7:0] GPO_IDX_C_DIR  = 8'h07;
	localparam logic [7:0] GPO_IDX_C_OUT  = 8'h08;
	localparam logic [7:0] GPO_IDX_D_IN   = 8'h09;
	localparam logic [7:0] GPO_IDX_D_DIR  = 8'h0A;
	localparam logic [7:0] GPO_IDX_D_OUT  = 8'h0B;
	localparam logic [7:0] GPO_IDX_SYSCTL = 8'h35;
	localparam logic [7:0] GPO_IDX_IRQ_ST = 8'h38;
	localparam logic [7:0] GPO_IDX_IRQ_MK = 8'h39;
	localparam logic [7:0] GPO_IDX_OVCTL  = 8'h3A;
	localparam logic [7:0] GPO_IDX_CHMSK  = 8'h3B;

	// ============================================================
	// Field masks and positions
	localparam logic [7:0] GPO_SYSCTL_WMASK = 8'h13;
	localparam logic [7:0] GPO_PORT_C_OUTPUT_DATA_MASK   = 8'h7F;
	localparam logic [7:0] GPO_RESET_BYTE   = 8'h00;
	localparam int unsigned GPO_PUD_BIT     = 4;
	// Override control bits
	localparam int unsigned GPO_OV_SERIAL_RECEIVER_ON  = 0;
	localparam int unsigned GPO_OV_SERIAL_TRANSMITTER_ON  = 1;
	localparam int unsigned GPO_OV_SYNC  = 2;
	localparam int unsigned GPO_OV_T0A   = 3;
	localparam int unsigned GPO_OV_T0B   = 4;
	localparam int unsigned GPO_OV_T2B   = 5;
	localparam int unsigned GPO_OV_EI0   = 6;
	localparam int unsigned GPO_OV_EI1   = 7;
	localparam int unsigned GPO_OV_GRPD  = 8;
	localparam int unsigned GPO_OV_GRPC  = 9;
	localparam int unsigned GPO_OV_W     = 10;
	localparam logic [9:0] GPO_OV_RESET  = 10'h000;
endpackage

// ---- rtl/gpo_ports.sv ----
/*
 General purpose ports B, C, D with port D peripheral overrides.
 Assumes pin inputs on i_clock domain rules; Wishbone classic slave.
*/
// Our own choice: register access over Wishbone.
// Functional notes
// - Receiver enabled forces port D pin 0 to input.
// - Forced pin 0 pull-up follows its data bit unless pull-ups disabled.
// - Port D pin input enable, except pin 2, forced on when change mask and group enable set.
// - Pin 3 input enable also forced by external interrupt one enable.
// - Pin 2 input enable by interrupt zero or mask with port C group enable.
// - Pins 6,5 take timer0 compares; pin 4 serial clock in sync mode.
// - Transmitter drives pin 1 output without pull-up; pin 3 timer2 compare B.
// - Global pull-up disable bit 4 turns every pull-up off.
// - System control resets zero; bits 4,1,0 writable, others read only.
// - Port B data register eight bits read/write, reset zero.
// - Each port direction register resets zero, pins start as inputs.
// - Input sense registers are read only and follow the pins.
// - Port C bit 7 reads zero and is not writable.
// - Port D full eight bit data and direction, read-only sense.
// - Transmitter enabled drives pin 1 as output regardless of direction.
module gpo_ports
	import gpo_pkg::*;
(
	input  wire logic                              i_clock,
	input  wire logic                              i_nrst,
	input  wire logic                              i_wb_cyc,
	input  wire logic                              i_wb_stb,
	input  wire logic                              i_wb_we,
	input  wire logic [gpo_pkg::GPO_ADDR_W-1:0]   i_wb_adr,
	input  wire logic [3:0]                        i_wb_sel,
	input  wire logic [gpo_pkg::GPO_DATA_W-1:0]   i_wb_dat,
	output logic      [gpo_pkg::GPO_DATA_W-1:0]   o_wb_dat,
	output logic                                   o_wb_ack,
	output logic                                   o_irq,
	input  wire logic [gpo_pkg::GPO_PORT_W-1:0]   i_pin_b,
	input  wire logic [gpo_pkg::GPO_PORT_W-1:0]   i_pin_c,
	input  wire logic [gpo_pkg::GPO_PORT_W-1:0]   i_pin_d,
	output logic      [gpo_pkg::GPO_PORT_W-1:0]   o_pin_b,
	output logic      [gpo_pkg::GPO_PORT_W-1:0]   o_pin_b_oe,
	output logic      [gpo_pkg::GPO_PORT_W-1:0]   o_pullup_b,
	output logic      [gpo_pkg::GPO_PORT_W-1:0]   o_pin_c,
	output logic      [gpo_pkg::GPO_PORT_W-1:0]   o_pin_c_oe,
	output logic      [gpo_pkg::GPO_PORT_W-1:0]   o_pullup_c,
	output logic      [gpo_pkg::GPO_PORT_W-1:0]   o_pin_d,
	output logic      [gpo_pkg::GPO_PORT_W-1:0]   o_pin_d_oe,
	output logic      [gpo_pkg::GPO_PORT_W-1:0]   o_pullup_d,
	output logic      [gpo_pkg::GPO_PORT_W-1:0]   o_input_enable_d,
	output logic      [gpo_pkg::GPO_PORT_W-1:0]   o_sync_pin_d,
	input  wire logic                              i_timer0_compare_a_out,
	input  wire logic                              i_timer0_compare_b_out,
	input  wire logic                              i_timer2_compare_b_out,
	input  wire logic                              i_serial_ext_clock,
	input  wire logic                              i_serial_tx_data
);
	import gpo_pkg::*;

	// ============================================================
	// State
	typedef struct packed {
		logic [7:0]         b_out;
		logic [7:0]         b_dir;
		logic [7:0]         c_out;
		logic [7:0]         c_dir;
		logic [7:0]         d_out;
		logic [7:0]         d_dir;
		logic [7:0]         sysctl;
		logic [GPO_OV_W-1:0] ovctl;
		logic [7:0]         chmsk;
		logic [7:0]         irq_st;
		logic [7:0]         irq_mk;
		logic [23:0]        sync1;
		logic [23:0]        sync2;
		logic [7:0]         d_prev;
		logic               ack;
		logic [31:0]        rdat;
	} gpo_state_t;

	gpo_state_t st_r;
	gpo_state_t st_nxt;

	// Byte lane 0 write; lane 1 holds data only for override control bits 9:8
	function automatic logic [7:0] gpo_wr(input logic [7:0] old, input logic [7:0] wd,
			input logic [7:0] wmask);
		gpo_wr = (old & ~wmask) | (wd & wmask);
	endfunction

	// Plain pull-up term shared by all ports
	function automatic logic [7:0] gpo_pull(input logic [7:0] dir, input logic [7:0] dout,
			input logic global_pullup_off);
		gpo_pull = ~dir & dout & {8{~global_pullup_off}};
	endfunction

	logic       global_pullup_off;
	logic [7:0] pin_b_s;
	logic [7:0] pin_c_s;
	logic [7:0] pin_d_s;
	logic       req;
	logic       wr_en;
	logic [7:0] wd;
	logic [7:0] d_ie;

	assign global_pullup_off     = st_r.sysctl[GPO_PUD_BIT];
	assign pin_b_s = st_r.sync2[7:0];
	assign pin_c_s = st_r.sync2[15:8] & GPO_PORT_C_OUTPUT_DATA_MASK;
	assign pin_d_s = st_r.sync2[23:16];
	assign req     = i_wb_cyc & i_wb_stb & ~st_r.ack;
	assign wr_en   = req & i_wb_we & i_wb_sel[0];
	assign wd      = i_wb_dat[7:0];

	// ============================================================
	// Pin drive, ports B and C
	always_comb begin
		o_pin_b    = st_r.b_out;
		o_pin_b_oe = st_r.b_dir;
		o_pullup_b = gpo_pull(st_r.b_dir, st_r.b_out, global_pullup_off);
		o_pin_c    = st_r.c_out;
		o_pin_c_oe = st_r.c_dir & GPO_PORT_C_OUTPUT_DATA_MASK;
		o_pullup_c = gpo_pull(st_r.c_dir, st_r.c_out, global_pullup_off) & GPO_PORT_C_OUTPUT_DATA_MASK;
	end

	// ============================================================
	// Port D with peripheral overrides
	always_comb begin
		o_pin_d    = st_r.d_out;
		o_pin_d_oe = st_r.d_dir;
		o_pullup_d = gpo_pull(st_r.d_dir, st_r.d_out, global_pullup_off);
		if (st_r.ovctl[GPO_OV_SERIAL_RECEIVER_ON]) begin
			o_pin_d_oe[0] = 1'b0;
			o_pullup_d[0] = st_r.d_out[0] & ~global_pullup_off;
		end
		if (st_r.ovctl[GPO_OV_SERIAL_TRANSMITTER_ON]) begin
			o_pin_d_oe[1] = 1'b1;
			o_pullup_d[1] = 1'b0;
			o_pin_d[1]    = i_serial_tx_data;
		end
		if (st_r.ovctl[GPO_OV_T2B]) begin
			o_pin_d[3] = i_timer2_compare_b_out;
		end
		if (st_r.ovctl[GPO_OV_SYNC]) begin
			o_pin_d[4] = i_serial_ext_clock;
		end
		if (st_r.ovctl[GPO_OV_T0B]) begin
			o_pin_d[5] = i_timer0_compare_b_out;
		end
		if (st_r.ovctl[GPO_OV_T0A]) begin
			o_pin_d[6] = i_timer0_compare_a_out;
		end
	end

	// Input enable override; value is always one when enabled
	always_comb begin
		d_ie    = st_r.chmsk & {8{st_r.ovctl[GPO_OV_GRPD]}};
		// Pin 2 uses the port C group enable, kept as printed
		d_ie[2] = st_r.ovctl[GPO_OV_EI0] | (st_r.chmsk[2] & st_r.ovctl[GPO_OV_GRPC]);
		d_ie[3] = st_r.ovctl[GPO_OV_EI1] | d_ie[3];
	end
	assign o_input_enable_d = d_ie;
	assign o_sync_pin_d     = pin_d_s;
	assign o_irq            = |(st_r.irq_st & st_r.irq_mk);
	assign o_wb_ack         = st_r.ack;
	assign o_wb_dat         = st_r.rdat;

	// ============================================================
	// Next state: registers, synchroniser, events
	always_comb begin
		st_nxt       = st_r;
		st_nxt.ack   = req;
		st_nxt.sync1 = {i_pin_d, i_pin_c, i_pin_b};
		st_nxt.sync2 = st_r.sync1;
		st_nxt.d_prev = pin_d_s;
		st_nxt.rdat  = '0;
		if (req && !i_wb_we) begin
			unique case (i_wb_adr)
				GPO_IDX_B_IN:   st_nxt.rdat[7:0] = pin_b_s;
				GPO_IDX_B_DIR:  st_nxt.rdat[7:0] = st_r.b_dir;
				GPO_IDX_B_OUT:  st_nxt.rdat[7:0] = st_r.b_out;
				GPO_IDX_C_IN:   st_nxt.rdat[7:0] = pin_c_s;
				GPO_IDX_C_DIR:  st_nxt.rdat[7:0] = st_r.c_dir;
				GPO_IDX_C_OUT:  st_nxt.rdat[7:0] = st_r.c_out;
				GPO_IDX_D_IN:   st_nxt.rdat[7:0] = pin_d_s;
				GPO_IDX_D_DIR:  st_nxt.rdat[7:0] = st_r.d_dir;
				GPO_IDX_D_OUT:  st_nxt.rdat[7:0] = st_r.d_out;
				GPO_IDX_SYSCTL: st_nxt.rdat[7:0] = st_r.sysctl;
				GPO_IDX_IRQ_ST: st_nxt.rdat[7:0] = st_r.irq_st;
				GPO_IDX_IRQ_MK: st_nxt.rdat[7:0] = st_r.irq_mk;
				GPO_IDX_OVCTL:  st_nxt.rdat[GPO_OV_W-1:0] = st_r.ovctl;
				GPO_IDX_CHMSK:  st_nxt.rdat[7:0] = st_r.chmsk;
				default:        st_nxt.rdat = '0;
			endcase
		end
		// Clear by write-one first so a same-cycle event below wins
		if (wr_en && i_wb_adr == GPO_IDX_IRQ_ST) begin
			st_nxt.irq_st = st_r.irq_st & ~wd;
		end
		if (wr_en) begin
			unique case (i_wb_adr)
				GPO_IDX_B_DIR:  st_nxt.b_dir = wd;
				GPO_IDX_B_OUT:  st_nxt.b_out = wd;
				GPO_IDX_C_DIR:  st_nxt.c_dir = wd & GPO_PORT_C_OUTPUT_DATA_MASK;
				GPO_IDX_C_OUT:  st_nxt.c_out = wd & GPO_PORT_C_OUTPUT_DATA_MASK;
				GPO_IDX_D_DIR:  st_nxt.d_dir = wd;
				GPO_IDX_D_OUT:  st_nxt.d_out = wd;
				GPO_IDX_SYSCTL: st_nxt.sysctl = gpo_wr(st_r.sysctl, wd, GPO_SYSCTL_WMASK);
				GPO_IDX_IRQ_MK: st_nxt.irq_mk = wd;
				GPO_IDX_OVCTL: begin
					if (i_wb_sel[1]) begin
						st_nxt.ovctl = i_wb_dat[GPO_OV_W-1:0];
					end else begin
						st_nxt.ovctl[7:0] = wd;
					end
				end
				GPO_IDX_CHMSK:  st_nxt.chmsk = wd;
				default: begin
				end
			endcase
		end
		// Pin change events on enabled input-sense pins
		st_nxt.irq_st = st_nxt.irq_st | ((pin_d_s ^ st_r.d_prev) & d_ie);
	end

	// ============================================================
	// Registers
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule

// ---- verif/gpo_pin_board.sv ----
/*
 Board model of one 8-pin port: pads from drive, pull-up and outside level.
 Assumes the outside level is driven by the bench.
*/
module gpo_pin_board (
	input  wire logic [7:0] i_out,
	input  wire logic [7:0] i_oe,
	input  wire logic [7:0] i_pullup,
	input  wire logic [7:0] i_float,
	output logic      [7:0] o_pad
);
	timeunit 1ns;
	timeprecision 1ps;
	// Outside source is weak: a pull-up wins over it
	assign o_pad = (i_oe & i_out) | (~i_oe & (i_pullup | i_float));
endmodule

// ---- verif/gpo_ports_asserts.sv ----
/*
 Port checker for gpo_ports.
 Assumes one clock domain and a synchronous active-low reset.
*/
module gpo_ports_asserts
	import gpo_pkg::*;
(
	input wire logic                            i_clock,
	input wire logic                            i_nrst,
	input wire logic                            i_wb_cyc,
	input wire logic                            i_wb_stb,
	input wire logic [gpo_pkg::GPO_DATA_W-1:0] o_wb_dat,
	input wire logic                            o_wb_ack,
	input wire logic                            o_irq,
	input wire logic [gpo_pkg::GPO_PORT_W-1:0] i_pin_d,
	input wire logic [gpo_pkg::GPO_PORT_W-1:0] o_pin_b_oe,
	input wire logic [gpo_pkg::GPO_PORT_W-1:0] o_pullup_b,
	input wire logic [gpo_pkg::GPO_PORT_W-1:0] o_pin_c,
	input wire logic [gpo_pkg::GPO_PORT_W-1:0] o_pin_c_oe,
	input wire logic [gpo_pkg::GPO_PORT_W-1:0] o_pullup_c,
	input wire logic [gpo_pkg::GPO_PORT_W-1:0] o_pin_d_oe,
	input wire logic [gpo_pkg::GPO_PORT_W-1:0] o_pullup_d,
	input wire logic [gpo_pkg::GPO_PORT_W-1:0] o_sync_pin_d
);
	timeunit 1ns;
	timeprecision 1ps;
	// ============================================================
	// Properties
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	property p_ack_rsp; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack; endproperty
	a_ack_rsp: assert property (p_ack_rsp) else $error("no ack after request");
	property p_ack_one; o_wb_ack |=> !o_wb_ack; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
	property p_ack_src; o_wb_ack |-> $past(i_wb_cyc && i_wb_stb); endproperty
	a_ack_src: assert property (p_ack_src) else $error("ack without request");
	property p_rd_idle; !o_wb_ack |-> o_wb_dat == '0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside ack");
	// Guarded so values held in reset never count as pin history
	property p_sync; $past(i_nrst) && $past(i_nrst, 2) |-> o_sync_pin_d == $past(i_pin_d, 2); endproperty
	a_sync: assert property (p_sync) else $error("pin sync depth wrong");
	property p_c7; !o_pin_c[7] && !o_pin_c_oe[7] && !o_pullup_c[7]; endproperty
	a_c7: assert property (p_c7) else $error("port C bit 7 active");
	property p_pu_drv; ((o_pin_b_oe & o_pullup_b) | (o_pin_c_oe & o_pullup_c) | (o_pin_d_oe & o_pullup_d)) == 8'h00; endproperty
	a_pu_drv: assert property (p_pu_drv) else $error("pull-up on driven pin");
	property p_rst; $rose(i_nrst) |-> o_pin_b_oe == 8'h00 && o_pin_d_oe == 8'h00 && !o_irq; endproperty
	a_rst: assert property (p_rst) else $error("outputs active after reset");
endmodule
bind gpo_ports gpo_ports_asserts chk_u (.i_clock(i_clock), .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc),
	.i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_irq(o_irq), .i_pin_d(i_pin_d),
	.o_pin_b_oe(o_pin_b_oe), .o_pullup_b(o_pullup_b), .o_pin_c(o_pin_c), .o_pin_c_oe(o_pin_c_oe),
	.o_pullup_c(o_pullup_c), .o_pin_d_oe(o_pin_d_oe), .o_pullup_d(o_pullup_d), .o_sync_pin_d(o_sync_pin_d));

// ---- verif/tb.sv ----
/*
 Self-checking bench for gpo_ports.
 Assumes the board models and the bound checker.
*/
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock, i_nrst, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, o_irq;
	logic [3:0] i_wb_sel;
	logic [7:0] i_wb_adr, flt, q, r, d, m, i_pin_b, i_pin_c, i_pin_d, o_pin_b, o_pin_b_oe, o_pullup_b;
	logic [7:0] o_pin_c, o_pin_c_oe, o_pullup_c, o_pin_d, o_pin_d_oe, o_pullup_d, o_input_enable_d;
	logic [31:0] i_wb_dat, o_wb_dat;
	logic [4:0] pv;
	logic [9:0] ov;
	logic i_timer0_compare_a_out, i_timer0_compare_b_out, i_timer2_compare_b_out, i_serial_ext_clock, i_serial_tx_data;
	int err_total, n_tests, seed;
	logic [7:0] ix [7] = '{8'h04, 8'h05, 8'h07, 8'h08, 8'h0A, 8'h0B, 8'h35};
	logic [7:0] mk [7] = '{8'hFF, 8'hFF, 8'h7F, 8'h7F, 8'hFF, 8'hFF, 8'h13};
	assign {i_timer0_compare_a_out, i_timer0_compare_b_out, i_serial_ext_clock, i_timer2_compare_b_out, i_serial_tx_data} = pv;
	gpo_ports dut_u (.i_clock, .i_nrst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat,
		.o_wb_ack, .o_irq, .i_pin_b, .i_pin_c, .i_pin_d, .o_pin_b, .o_pin_b_oe, .o_pullup_b, .o_pin_c, .o_pin_c_oe,
		.o_pullup_c, .o_pin_d, .o_pin_d_oe, .o_pullup_d, .o_input_enable_d, .o_sync_pin_d(), .i_timer0_compare_a_out,
		.i_timer0_compare_b_out, .i_timer2_compare_b_out, .i_serial_ext_clock, .i_serial_tx_data);
	gpo_pin_board b_u (.i_out(o_pin_b), .i_oe(o_pin_b_oe), .i_pullup(o_pullup_b), .i_float(flt), .o_pad(i_pin_b));
	gpo_pin_board c_u (.i_out(o_pin_c), .i_oe(o_pin_c_oe), .i_pullup(o_pullup_c), .i_float(flt), .o_pad(i_pin_c));
	gpo_pin_board d_u (.i_out(o_pin_d), .i_oe(o_pin_d_oe), .i_pullup(o_pullup_d), .i_float(flt), .o_pad(i_pin_d));
	// ============================================================
	// Helpers
	function automatic logic [7:0] ien(input logic [9:0] v, input logic [7:0] mm);
		logic [7:0] e;
		e = mm & {8{v[8]}};
		e[2] = v[6] | (mm[2] & v[9]);
		e[3] = v[7] | e[3];
		return e;
	endfunction
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Holds the request until ack is sampled; only the watchdog ends a lost ack
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [7:0] rd);
		int n;
		n = 0;
		{i_wb_cyc, i_wb_stb, i_wb_we} <= {2'b11, w};
		i_wb_sel <= 4'hF;
		i_wb_adr <= a;
		i_wb_dat <= wd;
		@(posedge i_clock);
		while (o_wb_ack !== 1'b1) begin
			@(posedge i_clock);
			n++;
		end
		// Ack is due one cycle after the request is taken, never later
		chk(8'(n), 8'h01);
		rd = o_wb_dat[7:0];
		{i_wb_cyc, i_wb_stb} <= 2'b00;
		@(posedge i_clock);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ============================================================
	// Sequence
	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	initial begin
		repeat (20000) @(posedge i_clock);
		err_total++;
		end_of_test();
	end
	initial begin
		seed = 37605;
		{i_nrst, i_wb_cyc, i_wb_stb, i_wb_we} = 4'h0;
		{i_wb_sel, i_wb_adr, i_wb_dat, flt, pv} = {4'hF, 8'h00, 32'h0, 8'h00, 5'h00};
		repeat (4) @(posedge i_clock);
		i_nrst <= 1'b1;
		@(posedge i_clock);
		foreach (ix[k]) begin
			bus(1'b0, ix[k], 32'h0, q);
			chk(q, 8'h00);
		end
		foreach (ix[k]) begin
			d = 8'($random(seed));
			bus(1'b1, ix[k], {24'h0, d}, r);
			bus(1'b0, ix[k], 32'h0, q);
			chk(q, d & mk[k]);
		end
		bus(1'b1, 8'h20, 32'hFF, r);
		bus(1'b0, 8'h20, 32'h0, q);
		chk(q, 8'h00);
		bus(1'b1, 8'h35, 32'h10, r);
		bus(1'b1, 8'h04, 32'h0, r);
		bus(1'b1, 8'h07, 32'h0, r);
		bus(1'b1, 8'h0A, 32'h0, r);
		bus(1'b1, 8'h05, 32'hFF, r);
		chk(o_pullup_b, 8'h00);
		flt <= 8'($random(seed));
		bus(1'b1, 8'h09, 32'hFF, r);
		bus(1'b0, 8'h03, 32'h0, q);
		chk(q, flt);
		bus(1'b0, 8'h06, 32'h0, q);
		chk(q, flt & 8'h7F);
		bus(1'b0, 8'h09, 32'h0, q);
		chk(q, flt);
		bus(1'b1, 8'h35, 32'h0, r);
		chk(o_pullup_b, 8'hFF);
		bus(1'b1, 8'h0A, 32'hFF, r);
		bus(1'b1, 8'h0B, 32'h01, r);
		bus(1'b1, 8'h3A, 32'h3F, r);
		repeat (4) begin
			pv <= 5'($random(seed));
			repeat (2) @(posedge i_clock);
			chk(o_pin_d_oe, 8'hFE);
			chk(o_pullup_d, 8'h01);
			chk(o_pin_d & 8'hFE, {1'b0, pv[4:1], 1'b0, pv[0], 1'b0});
		end
		bus(1'b1, 8'h35, 32'h10, r);
		chk(o_pullup_d, 8'h00);
		repeat (8) begin
			m = 8'($random(seed));
			ov = 10'($random(seed));
			bus(1'b1, 8'h3B, {24'h0, m}, r);
			bus(1'b1, 8'h3A, {22'h0, ov}, r);
			chk(o_input_enable_d, ien(ov, m));
		end
		// Interrupt on a pin-7 change, first masked, then shown, then cleared
		bus(1'b1, 8'h0A, 32'h0, r);
		bus(1'b1, 8'h3A, 32'h100, r);
		bus(1'b1, 8'h3B, 32'h80, r);
		bus(1'b1, 8'h39, 32'h0, r);
		bus(1'b1, 8'h38, 32'hFF, r);
		flt <= flt ^ 8'h80;
		repeat (6) @(posedge i_clock);
		chk({7'h00, o_irq}, 8'h00);
		bus(1'b0, 8'h38, 32'h0, q);
		chk(q, 8'h80);
		bus(1'b1, 8'h39, 32'h80, r);
		chk({7'h00, o_irq}, 8'h01);
		bus(1'b1, 8'h38, 32'h80, r);
		chk({7'h00, o_irq}, 8'h00);
		end_of_test();
	end
endmodule
